// ==== src/lpd_dim_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module lpd_dim_divider
    import lpd_pkg::*;
(
    input wire logic clock_in, // System clock
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic boundary_in, // One-cycle PWM period boundary
    input wire logic [PER_CODE_W-1:0] period_code_in, // Dimming period code
    output logic update_out // One-cycle duty update strobe
);
    logic [PERIOD_CNT_W-1:0] count_reg;
    logic [PERIOD_CNT_W-1:0] limit;
    logic [PER_CODE_W-1:0] eff_code;

    // Codes above five saturate at every 32 periods
    assign eff_code = (period_code_in > PERIOD_CODE_MAX) ? PERIOD_CODE_MAX : period_code_in;
    assign limit = PERIOD_CNT_W'((32'd1 << eff_code) - 32'd1);

    // Compare with >= so a shortened period takes hold at the next boundary
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count_reg <= '0;
            update_out <= 1'b0;
        end else if (boundary_in) begin
            if (count_reg >= limit) begin
                count_reg <= '0;
                update_out <= 1'b1;
            end else begin
                count_reg <= count_reg + 1'b1;
                update_out <= 1'b0;
            end
        end else begin
            update_out <= 1'b0;
        end
    end
endmodule : lpd_dim_divider
`default_nettype wire

// ==== src/lpd_pkg.sv ====
package lpd_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 13;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_PHASE_9_11 = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_GROUP_BCAST = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_0_2 = 5'h19;

    // Phase register field positions
    localparam int PH_LED9_LSB = 0;
    localparam int PH_LED10_LSB = 4;
    localparam int PH_LED11_LSB = 8;
    localparam int PH_CODE_W = 4;

    // Broadcast register field positions
    localparam int BC_CODE_LSB = 0;
    localparam int BC_MASK_LSB = 4;
    localparam int BC_MASK_W = 4;

    // Period register field positions
    localparam int PER_LED0_LSB = 0;
    localparam int PER_LED1_LSB = 4;
    localparam int PER_LED2_LSB = 8;
    localparam int PER_CODE_W = 3;

    // Values after reset
    localparam logic [PH_CODE_W-1:0] PHASE_CODE_RESET = 4'h0;
    localparam logic [BC_MASK_W-1:0] BCAST_MASK_RESET = 4'h1;
    localparam logic [PER_CODE_W-1:0] PERIOD_CODE_RESET = 3'h0;

    // Timing counts
    localparam int PWM_PERIOD_CYCLES = 4096;
    localparam int PHASE_STEPS = 12;
    localparam logic [PER_CODE_W-1:0] PERIOD_CODE_MAX = 3'h5;
    localparam int PERIOD_CNT_W = 5;
    localparam int LED_COUNT = 12;
endpackage : lpd_pkg

// ==== src/lpd_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Codes 0..11 shift PWM start by 30 degrees
// - Codes 12..14 give zero shift, 15 undefined
// - LED10 phase bits 7:4, LED9 bits 3:0
// - Broadcast register 0x18, mask and period fields
// - Broadcast copies period code to member LEDs
// - Mask bits select groups A to D
// - Zero mask skips broadcast, keeps stored mask
// - Membership comes from the per-group membership input ports
// - Period codes 0..5 update every 2^code periods
// - Codes six and seven behave like five
// - One PWM period is 4096 clocks
// - Register 0x19 holds LED 0..2 period codes
// - Phase register 0x14 also holds LED11 bits 11:8
module lpd_regs
    import lpd_pkg::*;
#(
    parameter int PERIOD_CYCLES = PWM_PERIOD_CYCLES // Clocks per PWM period
) (
    input wire logic clock_in, // System clock, 25 MHz
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic reg_write_in, // One-cycle register write strobe
    input wire logic reg_read_in, // One-cycle register read strobe
    input wire logic [ADDR_W-1:0] reg_addr_in, // Register offset
    input wire logic [DATA_W-1:0] reg_wdata_in, // Write data
    input wire logic [LED_COUNT-1:0] group_a_membership_in, // LEDs in group A
    input wire logic [LED_COUNT-1:0] group_b_membership_in, // LEDs in group B
    input wire logic [LED_COUNT-1:0] group_c_membership_in, // LEDs in group C
    input wire logic [LED_COUNT-1:0] group_d_membership_in, // LEDs in group D
    output logic [DATA_W-1:0] reg_rdata_out, // Read data
    output logic reg_rvalid_out, // Read data valid pulse
    output logic broadcast_strobe_out, // Broadcast executed pulse
    output logic [LED_COUNT-1:0] broadcast_led_mask_out, // LEDs hit by broadcast
    output logic [PER_CODE_W-1:0] broadcast_code_out, // Code being broadcast
    output logic period_boundary_out, // PWM period boundary pulse
    output logic [11:0] pwm_count_out, // Free-running PWM counter
    output logic [11:0] phase_offset_led9_out, // LED9 start offset in clocks
    output logic [11:0] phase_offset_led10_out, // LED10 start offset in clocks
    output logic [11:0] phase_offset_led11_out, // LED11 start offset in clocks
    output logic [2:0] duty_update_out // Duty update strobes, LEDs 0..2
);
    logic [PH_CODE_W-1:0] phase_code_led9;
    logic [PH_CODE_W-1:0] phase_code_led10;
    logic [PH_CODE_W-1:0] phase_code_led11;
    logic [BC_MASK_W-1:0] broadcast_group_mask;
    logic [PER_CODE_W-1:0] broadcast_period_code;
    logic [PER_CODE_W-1:0] period_code_led [3];
    logic [11:0] pwm_cnt_reg;
    logic boundary_reg;
    logic [2:0] upd;

    logic wr_phase;
    logic wr_group;
    logic wr_period;
    logic [BC_MASK_W-1:0] wr_mask;
    logic [PER_CODE_W-1:0] wr_code;
    logic [LED_COUNT-1:0] member_mask;
    logic bcast_go;

    assign wr_phase = reg_write_in && (reg_addr_in == ADDR_PHASE_9_11);
    assign wr_group = reg_write_in && (reg_addr_in == ADDR_GROUP_BCAST);
    assign wr_period = reg_write_in && (reg_addr_in == ADDR_PERIOD_0_2);
    assign wr_mask = reg_wdata_in[BC_MASK_LSB +: BC_MASK_W];
    assign wr_code = reg_wdata_in[BC_CODE_LSB +: PER_CODE_W];
    assign bcast_go = wr_group && (wr_mask != '0);

    // Union of all selected groups
    always_comb begin
        member_mask = '0;
        if (wr_mask[0]) member_mask = member_mask | group_a_membership_in;
        if (wr_mask[1]) member_mask = member_mask | group_b_membership_in;
        if (wr_mask[2]) member_mask = member_mask | group_c_membership_in;
        if (wr_mask[3]) member_mask = member_mask | group_d_membership_in;
    end

    // Phase-select register
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            phase_code_led9 <= PHASE_CODE_RESET;
            phase_code_led10 <= PHASE_CODE_RESET;
            phase_code_led11 <= PHASE_CODE_RESET;
        end else if (wr_phase) begin
            phase_code_led9 <= reg_wdata_in[PH_LED9_LSB +: PH_CODE_W];
            phase_code_led10 <= reg_wdata_in[PH_LED10_LSB +: PH_CODE_W];
            phase_code_led11 <= reg_wdata_in[PH_LED11_LSB +: PH_CODE_W];
        end
    end

    // Broadcast register; a zero mask write is dropped whole
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            broadcast_group_mask <= BCAST_MASK_RESET;
            broadcast_period_code <= PERIOD_CODE_RESET;
        end else if (bcast_go) begin
            broadcast_group_mask <= wr_mask;
            broadcast_period_code <= wr_code;
        end
    end

    // Broadcast strobe toward banks holding the other LEDs
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            broadcast_strobe_out <= 1'b0;
            broadcast_led_mask_out <= '0;
            broadcast_code_out <= PERIOD_CODE_RESET;
        end else begin
            broadcast_strobe_out <= bcast_go;
            broadcast_led_mask_out <= bcast_go ? member_mask : '0;
            if (bcast_go) broadcast_code_out <= wr_code;
        end
    end

    // Period codes for LEDs 0..2: direct write or broadcast
    for (genvar i = 0; i < 3; i++) begin : g_period
        always_ff @(posedge clock_in) begin
            if (reset_in) begin
                period_code_led[i] <= PERIOD_CODE_RESET;
            end else if (wr_period) begin
                period_code_led[i] <= reg_wdata_in[PER_LED0_LSB + 4*i +: PER_CODE_W];
            end else if (bcast_go && member_mask[i]) begin
                period_code_led[i] <= wr_code;
            end
        end

        lpd_dim_divider u_div (
            .clock_in(clock_in),
            .reset_in(reset_in),
            .boundary_in(boundary_reg),
            .period_code_in(period_code_led[i]),
            .update_out(upd[i])
        );
    end

    // PWM period counter
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pwm_cnt_reg <= '0;
            boundary_reg <= 1'b0;
        end else if (pwm_cnt_reg == 12'(PERIOD_CYCLES - 1)) begin
            pwm_cnt_reg <= '0;
            boundary_reg <= 1'b1;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 12'h001;
            boundary_reg <= 1'b0;
        end
    end

    function automatic logic [11:0] phase_offset(input logic [PH_CODE_W-1:0] code);
        int unsigned prod;
        prod = 32'(code) * 32'(PERIOD_CYCLES) / 32'(PHASE_STEPS);
        // Codes 12 and above fall back to no shift; 15 is not meant to be used
        if (code < 4'hC) begin
            return 12'(prod);
        end
        return 12'h000;
    endfunction : phase_offset

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            phase_offset_led9_out <= 12'h000;
            phase_offset_led10_out <= 12'h000;
            phase_offset_led11_out <= 12'h000;
        end else begin
            phase_offset_led9_out <= phase_offset(phase_code_led9);
            phase_offset_led10_out <= phase_offset(phase_code_led10);
            phase_offset_led11_out <= phase_offset(phase_code_led11);
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            period_boundary_out <= 1'b0;
            pwm_count_out <= 12'h000;
            duty_update_out <= 3'h0;
        end else begin
            period_boundary_out <= boundary_reg;
            pwm_count_out <= pwm_cnt_reg;
            duty_update_out <= upd;
        end
    end

    // Register readback; unmapped offsets and unused bits read zero
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            reg_rdata_out <= '0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_read_in;
            reg_rdata_out <= '0;
            if (reg_read_in) begin
                case (reg_addr_in)
                    ADDR_PHASE_9_11: begin
                        reg_rdata_out <= {1'b0, phase_code_led11, phase_code_led10,
                                          phase_code_led9};
                    end
                    ADDR_GROUP_BCAST: begin
                        reg_rdata_out <= {5'h00, broadcast_group_mask, 1'b0,
                                          broadcast_period_code};
                    end
                    ADDR_PERIOD_0_2: begin
                        reg_rdata_out <= {2'h0, period_code_led[2], 1'b0, period_code_led[1],
                                          1'b0, period_code_led[0]};
                    end
                    default: begin
                        reg_rdata_out <= '0;
                    end
                endcase
            end
        end
    end
endmodule : lpd_regs
`default_nettype wire

// ==== test/lpd_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module lpd_regs_props
    import lpd_pkg::*;
#(
    parameter int PERIOD_CYCLES = PWM_PERIOD_CYCLES // Clocks per period
) (
    input wire logic clock_in, // Clock
    input wire logic reset_in, // Reset
    input wire logic reg_write_in, // Write
    input wire logic [ADDR_W-1:0] reg_addr_in, // Offset
    input wire logic [DATA_W-1:0] reg_wdata_in, // Data
    input wire logic [LED_COUNT-1:0] group_a_membership_in, // Group A
    input wire logic [LED_COUNT-1:0] group_b_membership_in, // Group B
    input wire logic [LED_COUNT-1:0] group_c_membership_in, // Group C
    input wire logic [LED_COUNT-1:0] group_d_membership_in, // Group D
    input wire logic [DATA_W-1:0] reg_rdata_out, // Read data
    input wire logic reg_rvalid_out, // Read valid
    input wire logic broadcast_strobe_out, // Broadcast done
    input wire logic [LED_COUNT-1:0] broadcast_led_mask_out, // LEDs hit
    input wire logic [PER_CODE_W-1:0] broadcast_code_out, // Code sent
    input wire logic period_boundary_out, // Boundary
    input wire logic [11:0] phase_offset_led9_out, // LED9 offset
    input wire logic [11:0] phase_offset_led10_out, // LED10 offset
    input wire logic [2:0] duty_update_out // Duty strobes
);
    logic [11:0] gap_reg;
    logic seen_reg;
    logic bc_wr;
    logic [11:0] hit;
    assign bc_wr = reg_write_in && reg_addr_in == ADDR_GROUP_BCAST;
    assign hit = ({12{reg_wdata_in[4]}} & group_a_membership_in) | ({12{reg_wdata_in[5]}} &
        group_b_membership_in) | ({12{reg_wdata_in[6]}} & group_c_membership_in) |
        ({12{reg_wdata_in[7]}} & group_d_membership_in);
    always_ff @(posedge clock_in) begin
        gap_reg <= (reset_in || period_boundary_out) ? 12'h000 : gap_reg + 12'h001;
    end
    // First boundary after reset has no known start point
    always_ff @(posedge clock_in) begin
        seen_reg <= reset_in ? 1'b0 : (seen_reg | period_boundary_out);
    end
    function automatic logic [11:0] ofs(input logic [3:0] c);
        return (c < 4'hC) ? 12'(int'(c) * PERIOD_CYCLES / 12) : 12'h000;
    endfunction : ofs
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    property p_unused; reg_rvalid_out && $past(reg_addr_in) == ADDR_PERIOD_0_2 |->
        (reg_rdata_out & 13'h1888) == 13'h0000; endproperty
    a_unused: assert property (p_unused) else $error("unused bits not zero");
    property p_bcast; bc_wr && reg_wdata_in[7:4] != 4'h0 |=> broadcast_strobe_out &&
        broadcast_code_out == $past(reg_wdata_in[2:0]); endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast missing");
    property p_skip; bc_wr && reg_wdata_in[7:4] == 4'h0 |=> !broadcast_strobe_out; endproperty
    a_skip: assert property (p_skip) else $error("zero mask broadcast");
    property p_mask; bc_wr && reg_wdata_in[7:4] != 4'h0 |=>
        broadcast_led_mask_out == $past(hit); endproperty
    a_mask: assert property (p_mask) else $error("wrong LED set");
    property p_gap; period_boundary_out && seen_reg |-> gap_reg == 12'(PERIOD_CYCLES - 1);
    endproperty
    a_gap: assert property (p_gap) else $error("period length wrong");
    property p_ph9; reg_write_in && reg_addr_in == ADDR_PHASE_9_11 |-> ##2
        phase_offset_led9_out == ofs($past(reg_wdata_in[3:0], 2)); endproperty
    a_ph9: assert property (p_ph9) else $error("LED9 offset wrong");
    property p_ph10; reg_write_in && reg_addr_in == ADDR_PHASE_9_11 |-> ##2
        phase_offset_led10_out == ofs($past(reg_wdata_in[7:4], 2)); endproperty
    a_ph10: assert property (p_ph10) else $error("LED10 offset wrong");
    property p_duty; |duty_update_out |-> $past(period_boundary_out); endproperty
    a_duty: assert property (p_duty) else $error("duty update off boundary");
endmodule : lpd_regs_props
bind lpd_regs lpd_regs_props #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_lpd_regs_props (.clock_in,
    .reset_in, .reg_write_in, .reg_addr_in, .reg_wdata_in, .group_a_membership_in,
    .group_b_membership_in, .group_c_membership_in, .group_d_membership_in, .reg_rdata_out,
    .reg_rvalid_out, .broadcast_strobe_out, .broadcast_led_mask_out, .broadcast_code_out,
    .period_boundary_out, .phase_offset_led9_out, .phase_offset_led10_out, .duty_update_out);
`default_nettype wire

// ==== test/lpd_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module lpd_regs_test;
    import lpd_pkg::*;
    localparam int P = 16;
    typedef struct packed {logic [4:0] a; logic [12:0] d; logic [12:0] e;} lpd_row_t;
    lpd_row_t rows [7] = '{'{5'h14, 13'h1FFF, 13'h0FFF}, '{5'h14, 13'h0ABC, 13'h0ABC},
        '{5'h18, 13'h1FF7, 13'h00F7}, '{5'h18, 13'h0035, 13'h0035}, '{5'h19, 13'h1FFF,
        13'h0777}, '{5'h19, 13'h0351, 13'h0351}, '{5'h10, 13'h1FFF, 13'h0000}};
    logic [11:0] grp [4] = '{12'h001, 12'h002, 12'h004, 12'h803};
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [4:0] reg_addr_in = 5'h00;
    logic [12:0] reg_wdata_in = 13'h0000;
    logic [12:0] reg_rdata_out;
    logic [12:0] got;
    logic reg_rvalid_out, broadcast_strobe_out, period_boundary_out;
    logic [11:0] broadcast_led_mask_out, pwm_count_out;
    logic [11:0] phase_offset_led9_out, phase_offset_led10_out, phase_offset_led11_out;
    logic [2:0] broadcast_code_out, duty_update_out;
    int errors = 0;
    int checks_done = 0;
    lpd_regs #(.PERIOD_CYCLES(P)) u_lpd_regs (.clock_in, .reset_in, .reg_write_in,
        .reg_read_in, .reg_addr_in, .reg_wdata_in, .group_a_membership_in(grp[0]),
        .group_b_membership_in(grp[1]), .group_c_membership_in(grp[2]),
        .group_d_membership_in(grp[3]), .reg_rdata_out, .reg_rvalid_out, .broadcast_strobe_out,
        .broadcast_led_mask_out, .broadcast_code_out, .period_boundary_out, .pwm_count_out,
        .phase_offset_led9_out, .phase_offset_led10_out, .phase_offset_led11_out,
        .duty_update_out);
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Entered and left just after a rising edge
    task automatic wr(input logic [4:0] a, input logic [12:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        @(posedge clock_in);
        #1;
        reg_write_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        reg_addr_in = a;
        reg_read_in = 1'b1;
        @(posedge clock_in);
        #1;
        reg_read_in = 1'b0;
        chk("read valid", {12'h000, reg_rvalid_out}, 13'h0001);
        got = reg_rdata_out;
    endtask : rd
    // Third gap is clean; earlier ones may straddle the code change
    task automatic gap(input int code);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clock_in);
                #1;
                n++;
            end while (duty_update_out[0] !== 1'b1 && n < 600);
        end
        chk("duty gap", 13'(n), 13'(P << (code > 5 ? 5 : code)));
    endtask : gap
    initial begin
        #800000;
        errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clock_in);
        #1;
        reset_in = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("readback", got, rows[i].e);
        end
        reset_in = 1'b1;
        @(posedge clock_in);
        #1;
        reset_in = 1'b0;
        rd(5'h18);
        chk("bcast reset", got, 13'h0010);
        rd(5'h19);
        chk("period reset", got, 13'h0000);
        rd(5'h14);
        chk("phase reset", got, 13'h0000);
        wr(5'h14, 13'h0B51);
        repeat (3) @(posedge clock_in);
        #1;
        chk("phase 9", {1'b0, phase_offset_led9_out}, 13'h0001);
        chk("phase 11", {1'b0, phase_offset_led11_out}, 13'h000E);
        wr(5'h14, 13'h0FDC);
        repeat (3) @(posedge clock_in);
        #1;
        chk("phase 10 high", {1'b0, phase_offset_led10_out}, 13'h0000);
        for (int g = 0; g < 4; g++) begin
            wr(5'h18, 13'((16 << g) | (g + 1)));
            chk("strobe", {12'h000, broadcast_strobe_out}, 13'h0001);
            chk("led mask", {1'b0, broadcast_led_mask_out}, {1'b0, grp[g]});
        end
        rd(5'h19);
        chk("bcast codes", got, 13'h0344);
        wr(5'h18, 13'h0065);
        chk("two groups", {1'b0, broadcast_led_mask_out}, 13'h0006);
        wr(5'h18, 13'h0002);
        chk("zero strobe", {12'h000, broadcast_strobe_out}, 13'h0000);
        rd(5'h18);
        chk("mask kept", got, 13'h0065);
        rd(5'h19);
        chk("codes kept", got, 13'h0554);
        for (int c = 0; c < 8; c++) begin
            wr(5'h19, 13'(c));
            gap(c);
        end
        // Counter wraps every P clocks
        got = {1'b0, pwm_count_out};
        @(posedge clock_in);
        #1;
        chk("pwm count", {1'b0, pwm_count_out}, 13'((got + 13'h0001) % P));
        close_out();
    end
endmodule : lpd_regs_test
`default_nettype wire
